// ==== rtl/lbc_top.sv ====
/*
 * LED bank cycle setup top: serial bus slave, register file, two group
 * sequencers and the output stage.
 * Assumes scl and sda arrive already synchronous to sys_clk_in and that the
 * system clock is much faster than the bus clock. rst_in is the power-on reset.
 */
`timescale 1ns/1ps
module lbc_top #(
	parameter int STEP_CYC = lbc_pkg::STEP_CYCLES // cycles per fade step
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic scl_in, // bus clock from host
	input wire logic sda_in, // bus data level
	output logic sda_out, // data drive level, always low
	output logic sda_oe_out, // high while pulling data low
	output logic [6:0] led_sink_out // high sinks LED current
);

	lbc_pkg::lbc_bus_state_e st_ff; // bus receiver state
	logic scl_q_ff; // bus clock one cycle ago
	logic sda_q_ff; // bus data one cycle ago
	logic [3:0] cnt_ff; // bits seen in this byte
	logic [7:0] shift_ff; // byte shifter
	logic oe_ff; // data line pull-down
	logic rd_mode_ff; // addressed for reading
	logic nack_ff; // host refused the last read byte
	logic [3:0] ptr_ff; // register pointer
	logic ai_ff; // auto-increment on
	logic wr_stb_ff; // one-cycle register write
	logic [3:0] wr_addr_ff;
	logic [7:0] wr_data_ff;
	logic [7:0] regs_ff [lbc_pkg::REG_COUNT]; // register file
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic byte_in; // eighth bit has been taken
	logic rd_load; // next read byte is fetched
	logic cmd_take; // command byte complete
	logic [7:0] rd_data; // register read value
	logic init_wr; // write to the init register
	logic [2:0] region0;
	logic [2:0] region1;
	logic [3:0] level0;
	logic [3:0] level1;

	// step the pointer, staying within the map
	function automatic logic [3:0] next_ptr(input logic [3:0] p);
		next_ptr = (p >= lbc_pkg::REG_LAST) ? lbc_pkg::REG_SEL_A : p + 4'h1;
	endfunction

	// pick one group's nibble from a packed register
	function automatic logic [3:0] nib(input logic [7:0] r, input logic second);
		nib = second ? r[lbc_pkg::NIB_SECOND_LSB +: 4] : r[lbc_pkg::NIB_FIRST_LSB +: 4];
	endfunction

	assign sda_out = 1'b0;
	assign sda_oe_out = oe_ff;
	assign scl_rise = scl_in & ~scl_q_ff;
	assign scl_fall = ~scl_in & scl_q_ff;
	assign bus_start = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
	assign bus_stop = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
	assign byte_in = cnt_ff == 4'h8;
	assign cmd_take = st_ff == lbc_pkg::BUS_CMD && scl_fall && byte_in;
	assign rd_load = scl_fall && ((st_ff == lbc_pkg::BUS_ADDR_ACK && rd_mode_ff) ||
		(st_ff == lbc_pkg::BUS_RDATA_ACK && !nack_ff));

	// previous bus levels for edge and condition detection
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else begin
			scl_q_ff <= scl_in;
			sda_q_ff <= sda_in;
		end
	end

	// bus protocol engine: address, command, then data bytes
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_ff <= lbc_pkg::BUS_IDLE;
			cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			oe_ff <= 1'b0;
			rd_mode_ff <= 1'b0;
			nack_ff <= 1'b0;
		end else if (bus_start) begin
			// start or repeated start: expect an address
			st_ff <= lbc_pkg::BUS_ADDR;
			cnt_ff <= 4'h0;
			oe_ff <= 1'b0;
		end else if (bus_stop) begin
			// stop ends the transaction
			st_ff <= lbc_pkg::BUS_IDLE;
			oe_ff <= 1'b0;
		end else begin
			unique case (st_ff)
				lbc_pkg::BUS_IDLE: begin
					oe_ff <= 1'b0;
				end
				lbc_pkg::BUS_ADDR, lbc_pkg::BUS_CMD, lbc_pkg::BUS_WDATA: begin
					if (scl_rise && !byte_in) begin
						// sample a bit, msb first
						shift_ff <= {shift_ff[6:0], sda_in};
						cnt_ff <= cnt_ff + 4'h1;
					end else if (scl_fall && byte_in) begin
						if (st_ff == lbc_pkg::BUS_ADDR) begin
							if (shift_ff[7:1] == lbc_pkg::DEV_ADDR) begin
								oe_ff <= 1'b1;
								rd_mode_ff <= shift_ff[0];
								st_ff <= lbc_pkg::BUS_ADDR_ACK;
							end else begin
								// not ours: stay off the bus until next start
								st_ff <= lbc_pkg::BUS_IDLE;
							end
						end else if (st_ff == lbc_pkg::BUS_CMD) begin
							oe_ff <= 1'b1;
							st_ff <= lbc_pkg::BUS_CMD_ACK;
						end else begin
							oe_ff <= 1'b1;
							st_ff <= lbc_pkg::BUS_WDATA_ACK;
						end
					end
				end
				lbc_pkg::BUS_ADDR_ACK: begin
					if (scl_fall) begin
						cnt_ff <= 4'h0;
						if (rd_mode_ff) begin
							// first read byte goes out straight after the ack
							shift_ff <= rd_data;
							oe_ff <= ~rd_data[7];
							st_ff <= lbc_pkg::BUS_RDATA;
						end else begin
							oe_ff <= 1'b0;
							st_ff <= lbc_pkg::BUS_CMD;
						end
					end
				end
				lbc_pkg::BUS_CMD_ACK, lbc_pkg::BUS_WDATA_ACK: begin
					if (scl_fall) begin
						// release the ack; every later byte is data
						oe_ff <= 1'b0;
						cnt_ff <= 4'h0;
						st_ff <= lbc_pkg::BUS_WDATA;
					end
				end
				lbc_pkg::BUS_RDATA: begin
					if (scl_rise) begin
						cnt_ff <= cnt_ff + 4'h1;
					end else if (scl_fall && byte_in) begin
						// hand the line to the host for its ack
						oe_ff <= 1'b0;
						st_ff <= lbc_pkg::BUS_RDATA_ACK;
					end else if (scl_fall) begin
						shift_ff <= {shift_ff[6:0], 1'b0};
						oe_ff <= ~shift_ff[6];
					end
				end
				lbc_pkg::BUS_RDATA_ACK: begin
					if (scl_rise) begin
						nack_ff <= sda_in;
					end else if (scl_fall && nack_ff) begin
						st_ff <= lbc_pkg::BUS_IDLE;
					end else if (scl_fall) begin
						cnt_ff <= 4'h0;
						shift_ff <= rd_data;
						oe_ff <= ~rd_data[7];
						st_ff <= lbc_pkg::BUS_RDATA;
					end
				end
				default: begin
					// unused codes recover to idle
					st_ff <= lbc_pkg::BUS_IDLE;
					oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// register write strobe, one cycle per data byte
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_stb_ff <= 1'b0;
			wr_addr_ff <= 4'h0;
			wr_data_ff <= 8'h00;
		end else begin
			wr_stb_ff <= st_ff == lbc_pkg::BUS_WDATA && scl_fall && byte_in && !bus_start && !bus_stop;
			wr_addr_ff <= ptr_ff;
			wr_data_ff <= shift_ff;
		end
	end

	// register pointer, loaded by the command byte
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ptr_ff <= lbc_pkg::REG_SEL_A;
			ai_ff <= 1'b0;
		end else if (cmd_take && !bus_start && !bus_stop) begin
			ptr_ff <= shift_ff[3:0];
			ai_ff <= shift_ff[lbc_pkg::CMD_AUTO_INC_BIT];
		end else if (ai_ff && (wr_stb_ff || rd_load)) begin
			ptr_ff <= next_ptr(ptr_ff);
		end
	end

	// register file; unmapped addresses are ignored
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < lbc_pkg::REG_COUNT; i++) begin
				regs_ff[i] <= lbc_pkg::REG_RESET_VAL;
			end
		end else if (wr_stb_ff && wr_addr_ff <= lbc_pkg::REG_LAST) begin
			regs_ff[wr_addr_ff] <= wr_data_ff;
		end
	end

	// read value; init register shows the running regions
	always_comb begin
		if (ptr_ff == lbc_pkg::REG_INIT) begin
			rd_data = {1'b0, region1, 1'b0, region0};
		end else if (ptr_ff <= lbc_pkg::REG_LAST) begin
			rd_data = regs_ff[ptr_ff];
		end else begin
			rd_data = 8'h00;
		end
	end

	assign init_wr = wr_stb_ff && wr_addr_ff == lbc_pkg::REG_INIT;

	// first group sequencer, low nibbles
	lbc_bank_seq #(
		.STEP_CYC(STEP_CYC)
	) u_seq0 (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.init_stb_in(init_wr && wr_data_ff[lbc_pkg::INIT_FIRST_REQ_BIT]),
		.init_start_in(wr_data_ff[lbc_pkg::INIT_FIRST_START_LSB +: 3]),
		.fade_on_code_in(nib(regs_ff[lbc_pkg::REG_FADE_ON], 1'b0)),
		.full_on_code_in(nib(regs_ff[lbc_pkg::REG_FULL_ON], 1'b0)),
		.fade_off_code_in(nib(regs_ff[lbc_pkg::REG_FADE_OFF], 1'b0)),
		.dark1_code_in(nib(regs_ff[lbc_pkg::REG_DARK_1], 1'b0)),
		.dark2_code_in(nib(regs_ff[lbc_pkg::REG_DARK_2], 1'b0)),
		.max_code_in(nib(regs_ff[lbc_pkg::REG_MAX_BRIGHT], 1'b0)),
		.region_out(region0),
		.level_out(level0)
	);

	// second group sequencer, high nibbles
	lbc_bank_seq #(
		.STEP_CYC(STEP_CYC)
	) u_seq1 (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.init_stb_in(init_wr && wr_data_ff[lbc_pkg::INIT_SECOND_REQ_BIT]),
		.init_start_in(wr_data_ff[lbc_pkg::INIT_SECOND_START_LSB +: 3]),
		.fade_on_code_in(nib(regs_ff[lbc_pkg::REG_FADE_ON], 1'b1)),
		.full_on_code_in(nib(regs_ff[lbc_pkg::REG_FULL_ON], 1'b1)),
		.fade_off_code_in(nib(regs_ff[lbc_pkg::REG_FADE_OFF], 1'b1)),
		.dark1_code_in(nib(regs_ff[lbc_pkg::REG_DARK_1], 1'b1)),
		.dark2_code_in(nib(regs_ff[lbc_pkg::REG_DARK_2], 1'b1)),
		.max_code_in(nib(regs_ff[lbc_pkg::REG_MAX_BRIGHT], 1'b1)),
		.region_out(region1),
		.level_out(level1)
	);

	// pins follow the select registers one clock later
	lbc_led_mux u_mux (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.sel_a_in(regs_ff[lbc_pkg::REG_SEL_A]),
		.sel_b_in(regs_ff[lbc_pkg::REG_SEL_B]),
		.sel_c_in(regs_ff[lbc_pkg::REG_SEL_C]),
		.level0_in(level0),
		.level1_in(level1),
		.led_sink_out(led_sink_out)
	);

endmodule

// ==== rtl/lbc_pkg.sv ====
/*
 * Shared constants and types for the LED bank cycle setup block: register
 * offsets, field positions, reset values, bus address, region and bus state
 * codes and cycle counts.
 * Assumes a single 200 MHz system clock; nothing here is synthesised alone.
 */
// What this block does
// - Start code selects regions A1 through E
// - Init bits 2-0 start, bit 3 applies
// - Select registers live at 0x00-0x02
// - Five durations 0x03-0x07, brightness follows
// - High nibble second group, low first
// - Command 0x10 starts at zero, auto-increments
// - Pattern runs once registers written, no command
// - Only power-on reset restores the defaults
package lbc_pkg;

	// register offsets on the serial bus
	localparam logic [3:0] REG_SEL_A = 4'h0;
	localparam logic [3:0] REG_SEL_B = 4'h1;
	localparam logic [3:0] REG_SEL_C = 4'h2;
	localparam logic [3:0] REG_FADE_ON = 4'h3;
	localparam logic [3:0] REG_FULL_ON = 4'h4;
	localparam logic [3:0] REG_FADE_OFF = 4'h5;
	localparam logic [3:0] REG_DARK_1 = 4'h6;
	localparam logic [3:0] REG_DARK_2 = 4'h7;
	localparam logic [3:0] REG_MAX_BRIGHT = 4'h8;
	localparam logic [3:0] REG_ONE_SHOT = 4'h9;
	localparam logic [3:0] REG_INIT = 4'hA;
	localparam logic [3:0] REG_LAST = 4'hA;
	localparam int REG_COUNT = 11;

	// value of every register after power-on reset
	localparam logic [7:0] REG_RESET_VAL = 8'h00;

	// field positions
	localparam int CMD_AUTO_INC_BIT = 4;
	localparam int NIB_FIRST_LSB = 0;
	localparam int NIB_SECOND_LSB = 4;
	localparam int INIT_FIRST_REQ_BIT = 3;
	localparam int INIT_SECOND_REQ_BIT = 7;
	localparam int INIT_FIRST_START_LSB = 0;
	localparam int INIT_SECOND_START_LSB = 4;

	// seven-bit bus address of this device
	localparam logic [6:0] DEV_ADDR = 7'h45;

	// length of one fade step in time and in clock cycles
	localparam int CLK_PERIOD_PS = 5000;
	localparam int STEP_TIME_US = 1000;
	// microseconds to picoseconds, then whole clock periods
	localparam int STEP_CYCLES = (STEP_TIME_US * 1000000) / CLK_PERIOD_PS;
	// fade steps per region, one per brightness level
	localparam logic [3:0] STEPS_LAST = 4'hF;
	// dimmer period in clock cycles, 15 slots for 16 levels
	localparam logic [3:0] DIM_SLOT_LAST = 4'hE;

	// intensity cycle regions, in running order
	typedef enum logic [2:0] {
		RGN_A1 = 3'h0,
		RGN_B1 = 3'h1,
		RGN_C1 = 3'h2,
		RGN_D = 3'h3,
		RGN_A2 = 3'h4,
		RGN_B2 = 3'h5,
		RGN_C2 = 3'h6,
		RGN_E = 3'h7
	} lbc_region_e;

	// serial bus receiver states
	typedef enum logic [3:0] {
		BUS_IDLE = 4'h0,
		BUS_ADDR = 4'h1,
		BUS_ADDR_ACK = 4'h2,
		BUS_CMD = 4'h3,
		BUS_CMD_ACK = 4'h4,
		BUS_WDATA = 4'h5,
		BUS_WDATA_ACK = 4'h6,
		BUS_RDATA = 4'h7,
		BUS_RDATA_ACK = 4'h8
	} lbc_bus_state_e;

endpackage

// ==== rtl/lbc_bank_seq.sv ====
/*
 * One LED group's intensity cycle: walks the eight regions with the
 * programmed durations and gives the current intensity level.
 * Assumes the duration and brightness codes are held steady by the register
 * file and that the init strobe is a one-cycle pulse.
 */
`timescale 1ns/1ps
module lbc_bank_seq #(
	parameter int STEP_CYC = lbc_pkg::STEP_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic init_stb_in, // restart the cycle
	input wire logic [2:0] init_start_in, // region to restart at
	input wire logic [3:0] fade_on_code_in,
	input wire logic [3:0] full_on_code_in,
	input wire logic [3:0] fade_off_code_in,
	input wire logic [3:0] dark1_code_in,
	input wire logic [3:0] dark2_code_in,
	input wire logic [3:0] max_code_in,
	output logic [2:0] region_out,
	output logic [3:0] level_out
);

	lbc_pkg::lbc_region_e region_ff; // current region
	logic [3:0] step_ff; // fade step inside the region
	logic [31:0] cyc_ff; // cycles inside the step
	logic [31:0] step_len; // cycles per step for this region
	logic [3:0] code; // duration code of this region
	logic [3:0] ramp; // step capped at the maximum

	// duration code that governs a region
	function automatic logic [3:0] dur_of(input lbc_pkg::lbc_region_e r, input logic [3:0] fon,
		input logic [3:0] full, input logic [3:0] foff, input logic [3:0] d1, input logic [3:0] d2);
		unique case (r)
			lbc_pkg::RGN_A1, lbc_pkg::RGN_A2: dur_of = fon;
			lbc_pkg::RGN_B1, lbc_pkg::RGN_B2: dur_of = full;
			lbc_pkg::RGN_C1, lbc_pkg::RGN_C2: dur_of = foff;
			lbc_pkg::RGN_D: dur_of = d1;
			lbc_pkg::RGN_E: dur_of = d2;
		endcase
	endfunction

	assign code = dur_of(region_ff, fade_on_code_in, full_on_code_in, fade_off_code_in,
		dark1_code_in, dark2_code_in);
	assign step_len = 32'(code) * 32'(STEP_CYC);
	assign ramp = (step_ff > max_code_in) ? max_code_in : step_ff;
	assign region_out = region_ff;

	// region walk; a zero code passes the region at once
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			region_ff <= lbc_pkg::RGN_A1;
			step_ff <= 4'h0;
			cyc_ff <= 32'h0;
		end else if (init_stb_in) begin
			region_ff <= lbc_pkg::lbc_region_e'(init_start_in);
			step_ff <= 4'h0;
			cyc_ff <= 32'h0;
		end else if (code == 4'h0 || (step_ff == lbc_pkg::STEPS_LAST && cyc_ff + 32'h1 >= step_len)) begin
			region_ff <= lbc_pkg::lbc_region_e'(3'(region_ff + 3'h1));
			step_ff <= 4'h0;
			cyc_ff <= 32'h0;
		end else if (cyc_ff + 32'h1 >= step_len) begin
			step_ff <= step_ff + 4'h1;
			cyc_ff <= 32'h0;
		end else begin
			cyc_ff <= cyc_ff + 32'h1;
		end
	end

	// level: ramp up, hold at max, ramp down, dark
	always_comb begin
		unique case (region_ff)
			lbc_pkg::RGN_A1, lbc_pkg::RGN_A2: level_out = ramp;
			lbc_pkg::RGN_B1, lbc_pkg::RGN_B2: level_out = max_code_in;
			lbc_pkg::RGN_C1, lbc_pkg::RGN_C2: level_out = max_code_in - ramp;
			lbc_pkg::RGN_D, lbc_pkg::RGN_E: level_out = 4'h0;
		endcase
	end

endmodule

// ==== rtl/lbc_led_mux.sv ====
/*
 * Output stage: dimmer slot counter and the per-pin source choice from the
 * three select registers.
 * Assumes open-drain LED pins, where a high sink output pulls the pin low.
 */
`timescale 1ns/1ps
module lbc_led_mux (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] sel_a_in,
	input wire logic [7:0] sel_b_in,
	input wire logic [7:0] sel_c_in,
	input wire logic [3:0] level0_in, // first group intensity
	input wire logic [3:0] level1_in, // second group intensity
	output logic [6:0] led_sink_out
);

	logic [3:0] slot_ff; // dimmer slot
	logic [6:0] sink_ff; // registered pin drive
	logic [6:0] nxt_sink;
	logic [2:0] src; // per-pin source code
	logic on0; // first group dimmer lit
	logic on1; // second group dimmer lit

	assign on0 = level0_in > slot_ff;
	assign on1 = level1_in > slot_ff;
	assign led_sink_out = sink_ff;

	// dimmer slot counter, 15 slots per period
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			slot_ff <= 4'h0;
		end else if (slot_ff == lbc_pkg::DIM_SLOT_LAST) begin
			slot_ff <= 4'h0;
		end else begin
			slot_ff <= slot_ff + 4'h1;
		end
	end

	// pin source: 00x off, 01x on, 1x0 first group, 1x1 second group
	always_comb begin
		nxt_sink = 7'h00;
		src = 3'h0;
		for (int i = 0; i < 7; i++) begin
			src = {sel_c_in[i], sel_b_in[i], sel_a_in[i]};
			if (src[2]) begin
				nxt_sink[i] = src[0] ? on1 : on0;
			end else begin
				nxt_sink[i] = src[1];
			end
		end
	end

	// registered pins, released at reset
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sink_ff <= 7'h00;
		end else begin
			sink_ff <= nxt_sink;
		end
	end

endmodule

// ==== sim/lbc_top_assertions.sv ====
/* port timing checks for lbc_top
   bound from tb_top; sees only the top ports */
`timescale 1ns/1ps
module lbc_top_assertions #(
	parameter int STEP_CYC = 2 // fade step length
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic [6:0] led_sink_out
);
	logic [7:0] rise_cnt_ff; // scl rises since last start
	// count bus clock rises, cleared by a start
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rise_cnt_ff <= 8'h00;
		end else if (scl_in && $past(scl_in) && $fell(sda_in)) begin
			rise_cnt_ff <= 8'h00;
		end else if ($rose(scl_in) && rise_cnt_ff != 8'hFF) begin
			rise_cnt_ff <= rise_cnt_ff + 8'h01;
		end
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	drive_low_a: assert property (sda_out == 1'b0) else $error("data drive level high");
	edge_align_a: assert property ($changed(sda_oe_out) |-> $past(scl_in, 2) && !$past(scl_in))
		else $error("data drive moved off the clock fall");
	drive_bound_a: assert property ($rose(sda_oe_out) |-> ##[1:300] !sda_oe_out)
		else $error("data drive held too long");
	hold_high_a: assert property (sda_oe_out && scl_in |=> sda_oe_out) else $error("drive dropped in clock high");
	cond_free_a: assert property (scl_in && $past(scl_in) && $changed(sda_in) |-> !sda_oe_out)
		else $error("device drove during start or stop");
	addr_ack_a: assert property ($rose(sda_oe_out) && rise_cnt_ff < 8'h09 |-> rise_cnt_ff == 8'h08)
		else $error("address ack at wrong bit");
	reset_quiet_a: assert property (disable iff (1'b0) rst_in |-> led_sink_out == 7'h00 && !sda_oe_out)
		else $error("outputs active in reset");
	release_quiet_a: assert property ($fell(rst_in) |-> ##1 (led_sink_out == 7'h00 && !sda_oe_out))
		else $error("outputs active after release");
endmodule

// ==== sim/lbc_host_model.sv ====
/* bus host model: drives scl and pulls the data line
   data line has a pull-up; tb_top calls the tasks */
`timescale 1ns/1ps
module lbc_host_model (
	input wire logic sys_clk_in,
	input wire logic sda_oe_in, // device pulls data low
	output logic scl_out,
	output logic sda_line_out // resolved data line
);
	logic scl_ff = 1'b1; // bus clock, idle high
	logic pull_ff = 1'b0; // host pulls data low
	assign scl_out = scl_ff;
	// pull-up wins when nobody pulls
	assign sda_line_out = !(pull_ff || sda_oe_in);
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	// data set in clock low, sampled mid clock high
	task automatic bit_xfer(input logic b, output logic s);
		pull_ff <= !b;
		wait_cyc(2);
		scl_ff <= 1'b1;
		wait_cyc(2);
		@(negedge sys_clk_in) s = sda_line_out;
		wait_cyc(2);
		scl_ff <= 1'b0;
		wait_cyc(2);
	endtask
	task automatic start_cond;
		pull_ff <= 1'b0;
		wait_cyc(2);
		scl_ff <= 1'b1;
		wait_cyc(4);
		pull_ff <= 1'b1; // data falls under high clock
		wait_cyc(4);
		scl_ff <= 1'b0;
		wait_cyc(2);
	endtask
	task automatic stop_cond;
		pull_ff <= 1'b1;
		wait_cyc(2);
		scl_ff <= 1'b1;
		wait_cyc(4);
		pull_ff <= 1'b0; // data rises under high clock
		wait_cyc(4);
	endtask
	// eight bits msb first, then the ack bit
	task automatic byte_xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], q[i]);
		end
		bit_xfer(ai, ao);
	endtask
	// address, command, data bytes in one write
	task automatic wr(input logic [6:0] adr, input logic [7:0] cmd, input logic [7:0] dat[$], output logic ack);
		logic [7:0] q;
		logic a;
		start_cond;
		byte_xfer({adr, 1'b0}, 1'b1, q, ack);
		if (ack === 1'b0) begin
			byte_xfer(cmd, 1'b1, q, a);
			foreach (dat[i]) begin
				byte_xfer(dat[i], 1'b1, q, a);
			end
		end
		stop_cond;
	endtask
	// set pointer, repeated start, read n bytes, nack last
	task automatic rd(input logic [7:0] cmd, input int n, output logic [7:0] got[$]);
		logic [7:0] q;
		logic a;
		got = '{};
		start_cond;
		byte_xfer({lbc_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a);
		byte_xfer(cmd, 1'b1, q, a);
		start_cond;
		byte_xfer({lbc_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a);
		for (int i = 0; i < n; i++) begin
			byte_xfer(8'hFF, logic'(i == n - 1), q, a);
			got.push_back(q);
		end
		stop_cond;
	endtask
endmodule

// ==== sim/tb_top.sv ====
/* self-checking bench for lbc_top
   bus traffic comes from lbc_host_model; one clock */
`timescale 1ns/1ps
module tb_top;
	localparam int STEP = 10; // short fade step
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b0; // power-on reset, raised at time zero so the design sees an edge
	logic scl, sda, sda_drv, sda_oe;
	logic [6:0] led;
	int error_cnt = 0;
	int n_tests = 0;
	lbc_top #(.STEP_CYC(STEP)) lbc_top_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe), .led_sink_out(led));
	lbc_host_model lbc_host_model_i (.sys_clk_in(sys_clk_in), .sda_oe_in(sda_oe), .scl_out(scl),
		.sda_line_out(sda));
	// 200 MHz clock
	initial begin
		forever #2.5 sys_clk_in = !sys_clk_in;
	end
	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp, input string what);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %b", $time, what, got);
		end
	endtask
	// sixteen cycles cover a whole dimmer period
	task automatic check_led(input logic [6:0] exp);
		repeat (16) begin
			@(negedge sys_clk_in);
			check8({1'b0, led}, {1'b0, exp}, "led sinks");
		end
	endtask
	task automatic wrap_up;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge sys_clk_in);
		error_cnt++;
		$display("[ERR] %0t run too long", $time);
		wrap_up;
	end
	initial begin
		logic [7:0] got[$];
		logic [7:0] exp[$];
		logic ack;
		rst_in <= 1'b1;
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		lbc_host_model_i.rd(8'h10, 11, got);
		// init byte shows live regions; both groups step together from reset
		foreach (got[i]) check8(got[i], (i == 10) ? {1'b0, got[i][2:0], 1'b0, got[i][2:0]} : 8'h00, "reset value");
		$display("test reset values done");
		exp = '{8'h01};
		lbc_host_model_i.wr(7'h44, 8'h10, exp, ack);
		check_bit(ack, 1'b1, "foreign address ack");
		// selects, five durations, max, plain store
		exp = '{8'h40, 8'h0F, 8'h70, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hA5};
		lbc_host_model_i.wr(lbc_pkg::DEV_ADDR, 8'h10, exp, ack);
		check_bit(ack, 1'b0, "own address ack");
		lbc_host_model_i.rd(8'h10, 10, got);
		foreach (got[i]) check8(got[i], exp[i], "auto-inc readback");
		$display("test auto-increment done");
		exp = '{8'h99};
		lbc_host_model_i.wr(lbc_pkg::DEV_ADDR, 8'h0A, exp, ack);
		lbc_host_model_i.rd(8'h0A, 1, got);
		check8(got[0], 8'h11, "both groups at B1");
		check_led(7'h3F);
		exp = '{8'h0B};
		lbc_host_model_i.wr(lbc_pkg::DEV_ADDR, 8'h0A, exp, ack);
		lbc_host_model_i.rd(8'h0A, 1, got);
		check8(got[0], 8'h13, "second group kept");
		check_led(7'h0F);
		$display("test running pattern done");
		for (int c = 0; c < 8; c++) begin
			exp = '{{1'b1, 3'(7 - c), 1'b1, 3'(c)}};
			lbc_host_model_i.wr(lbc_pkg::DEV_ADDR, 8'h0A, exp, ack);
			lbc_host_model_i.rd(8'h0A, 1, got);
			check8(got[0], {1'b0, 3'(7 - c), 1'b0, 3'(c)}, "start region");
		end
		$display("test start regions done");
		exp = '{8'h12, 8'h34};
		lbc_host_model_i.wr(lbc_pkg::DEV_ADDR, 8'h03, exp, ack);
		lbc_host_model_i.rd(8'h13, 2, got);
		check8(got[0], 8'h34, "fixed pointer last byte");
		check8(got[1], 8'hFF, "next register untouched");
		$display("test fixed pointer done");
		@(posedge sys_clk_in);
		rst_in <= 1'b1;
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		check_led(7'h00);
		lbc_host_model_i.rd(8'h10, 11, got);
		foreach (got[i]) check8(got[i], (i == 10) ? {1'b0, got[i][2:0], 1'b0, got[i][2:0]} : 8'h00, "value after reset");
		$display("test second reset done");
		wrap_up;
	end
endmodule
bind lbc_top lbc_top_assertions #(.STEP_CYC(STEP_CYC)) lbc_top_assertions_i (.sys_clk_in(sys_clk_in),
	.rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
	.led_sink_out(led_sink_out));
